// File: rtl/dpram_ctrl_pkg.sv
// package: pin groups, command codes and timing for the memory port controller
package dpram_ctrl_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [12:0] MAILBOX_LEFT = 13'h1FFE;
  localparam logic [12:0] MAILBOX_RIGHT = 13'h1FFF;
  localparam logic [2:0] SEM_ADDR_W = 3'h3;
  localparam int SEM_REQ_BIT = 0;
  // ****************************************************************
  // timing, 50 MHz clock
  // ****************************************************************
  localparam int CLK_NS = 20;
  localparam int PWE_NS = 40;
  localparam int SETUP_NS = 5;
  localparam int ACCESS_NS = 55;
  localparam int SWRD_NS = 5;
  localparam int PWE_CYC = (PWE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SWRD_CYC = (SWRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  // ****************************************************************
  // commands
  // ****************************************************************
  typedef enum logic [1:0] {
    CMD_READ = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_SEM_TAKE = 2'h2,
    CMD_SEM_FREE = 2'h3
  } cmd_t;

  typedef struct packed {
    cmd_t cmd;
    logic [12:0] addr;
    logic [7:0] wdata;
  } req_t;

  // control pins toward one memory port, all active low
  typedef struct packed {
    logic chip_select_n;
    logic semaphore_select_n;
    logic read_write_n;
    logic output_enable_n;
  } port_ctl_t;
endpackage

// File: rtl/pin_sync.sv
// three-stage input synchroniser, change taken once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] value
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;

  always_comb begin
    value_next = value_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        value_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      value_reg <= INIT;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule

// File: rtl/dpram_port_ctrl.sv
// controller that drives one port of the two-port memory through its pins
// ****************************************************************
// ****************************************************************
module dpram_port_ctrl #(
  parameter logic IS_LEFT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire dpram_ctrl_pkg::req_t req,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_granted,
  output logic irq_pending,
  output logic busy_seen,
  output logic [12:0] mem_addr,
  output dpram_ctrl_pkg::port_ctl_t mem_ctl,
  output logic [7:0] mem_data_out,
  output logic mem_data_oe,
  input wire logic [7:0] mem_data_in,
  input wire logic mem_busy_n,
  input wire logic mem_int_n
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b011,
    ST_RECOVER = 3'b010,
    ST_SEM_GAP = 3'b110,
    ST_SEM_READ = 3'b111
  } state_t;

  state_t state_reg, state_next;
  dpram_ctrl_pkg::req_t cur_reg, cur_next;
  logic [dpram_ctrl_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [12:0] addr_reg, addr_next;
  dpram_ctrl_pkg::port_ctl_t ctl_reg, ctl_next;
  logic [7:0] dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic granted_reg, granted_next;
  logic busy_seen_reg, busy_seen_next;
  logic [7:0] din_s;
  logic busy_s;
  logic int_s;

  // pins come from another timing domain
  pin_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_data (
    .clk(clk),
    .rst_n(rst_n),
    .pin(mem_data_in),
    .value(din_s)
  );
  pin_sync #(.WIDTH(2), .INIT(2'h3)) u_sync_flags (
    .clk(clk),
    .rst_n(rst_n),
    .pin({mem_busy_n, mem_int_n}),
    .value({busy_s, int_s})
  );

  // read data crosses four flops (three stages and the output register); three extra cycles are waited before latching
  localparam int SYNC_CYC = 3;

  function automatic logic [dpram_ctrl_pkg::CNT_W-1:0] cyc(input int n);
    cyc = n[dpram_ctrl_pkg::CNT_W-1:0];
  endfunction

  function automatic logic is_sem(input dpram_ctrl_pkg::cmd_t c);
    is_sem = (c == dpram_ctrl_pkg::CMD_SEM_TAKE) ||
             (c == dpram_ctrl_pkg::CMD_SEM_FREE);
  endfunction

  localparam dpram_ctrl_pkg::port_ctl_t CTL_IDLE = 4'hF;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    ctl_next = ctl_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    granted_next = granted_reg;
    busy_seen_next = busy_seen_reg;
    case (state_reg)
      ST_IDLE: begin
        ctl_next = CTL_IDLE;
        oe_next = 1'b0;
        if (req_valid) begin
          cur_next = req;
          // address moves only with read/write high
          addr_next = req.addr;
          busy_seen_next = 1'b0;
          cnt_next = cyc(dpram_ctrl_pkg::SETUP_CYC);
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (is_sem(cur_reg.cmd)) begin
          ctl_next.semaphore_select_n = 1'b0;
          ctl_next.chip_select_n = 1'b1;
        end else begin
          ctl_next.chip_select_n = 1'b0;
        end
        if (cnt_reg > cyc(1)) begin
          cnt_next = cnt_reg - cyc(1);
        end else begin
          cnt_next = (cur_reg.cmd == dpram_ctrl_pkg::CMD_READ) ?
            cyc(dpram_ctrl_pkg::ACCESS_CYC + SYNC_CYC) :
            cyc(dpram_ctrl_pkg::PWE_CYC);
          if (cur_reg.cmd == dpram_ctrl_pkg::CMD_READ) begin
            ctl_next.output_enable_n = 1'b0;
          end else begin
            ctl_next.output_enable_n = 1'b1;
            ctl_next.read_write_n = 1'b0;
            oe_next = 1'b1;
            dout_next = cur_reg.wdata;
            if (is_sem(cur_reg.cmd)) begin
              // low on bit zero asks, high gives back
              dout_next = 8'hFF;
              dout_next[dpram_ctrl_pkg::SEM_REQ_BIT] =
                (cur_reg.cmd != dpram_ctrl_pkg::CMD_SEM_TAKE);
            end
          end
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (!busy_s) begin
          busy_seen_next = 1'b1;
        end
        // slave-mode busy stretches the write strobe until released; a read strobe is not held
        if (!busy_s && !ctl_reg.read_write_n) begin
          cnt_next = cnt_reg;
        end else if (cnt_reg > cyc(1)) begin
          cnt_next = cnt_reg - cyc(1);
        end else begin
          rsp_data_next = din_s;
          // write ends on read/write rising; select released next
          ctl_next.read_write_n = 1'b1;
          ctl_next.output_enable_n = 1'b1;
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        oe_next = 1'b0;
        if (is_sem(cur_reg.cmd)) begin
          ctl_next = CTL_IDLE;
          ctl_next.semaphore_select_n = 1'b1;
          cnt_next = cyc(dpram_ctrl_pkg::SWRD_CYC);
          state_next = ST_SEM_GAP;
        end else begin
          ctl_next = CTL_IDLE;
          rsp_valid_next = 1'b1;
          granted_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_SEM_GAP: begin
        if (cnt_reg > cyc(1)) begin
          cnt_next = cnt_reg - cyc(1);
        end else begin
          // read back with chip select still high
          ctl_next.semaphore_select_n = 1'b0;
          ctl_next.output_enable_n = 1'b0;
          cnt_next = cyc(dpram_ctrl_pkg::ACCESS_CYC + SYNC_CYC);
          state_next = ST_SEM_READ;
        end
      end
      ST_SEM_READ: begin
        if (cnt_reg > cyc(1)) begin
          cnt_next = cnt_reg - cyc(1);
        end else begin
          rsp_data_next = din_s;
          // only one side reads low after contention
          granted_next = !din_s[dpram_ctrl_pkg::SEM_REQ_BIT];
          rsp_valid_next = 1'b1;
          ctl_next = CTL_IDLE;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cur_reg <= '0;
      cnt_reg <= '0;
      addr_reg <= '0;
      ctl_reg <= CTL_IDLE;
      dout_reg <= 8'h00;
      oe_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      granted_reg <= 1'b0;
      busy_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      ctl_reg <= ctl_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      granted_reg <= granted_next;
      busy_seen_reg <= busy_seen_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign req_ready = (state_reg == ST_IDLE);
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_granted = granted_reg;
  // mailbox flag: user clears it by reading its own mailbox word
  assign irq_pending = !int_s;
  // collision mark from busy, one side only
  assign busy_seen = busy_seen_reg;
  assign mem_addr = addr_reg;
  assign mem_ctl = ctl_reg;
  assign mem_data_out = dout_reg;
  assign mem_data_oe = oe_reg;

  // local mailbox word for users of this end
  localparam logic [12:0] OWN_MAILBOX = IS_LEFT ?
    dpram_ctrl_pkg::MAILBOX_LEFT : dpram_ctrl_pkg::MAILBOX_RIGHT;
endmodule

// File: testbench/dpram_port_checker.sv
// checker: pin discipline of one memory port controller
module dpram_port_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire dpram_ctrl_pkg::req_t req,
  input wire logic rsp_valid,
  input wire logic irq_pending,
  input wire logic [12:0] mem_addr,
  input wire dpram_ctrl_pkg::port_ctl_t mem_ctl,
  input wire logic [7:0] mem_data_out,
  input wire logic mem_data_oe,
  input wire logic mem_busy_n,
  input wire logic mem_int_n
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_strobe;
    !mem_ctl.read_write_n ##1 !mem_ctl.read_write_n;
  endsequence
  sequence s_take;
    req_valid && req_ready && req.cmd == dpram_ctrl_pkg::CMD_SEM_TAKE;
  endsequence
  a_addr_rw_high: assert property (
    $changed(mem_addr) |-> mem_ctl.read_write_n
      && $past(mem_ctl.read_write_n)) else $error("address moved in write");
  a_write_select: assert property (
    $fell(mem_ctl.read_write_n) |-> (!mem_ctl.chip_select_n
      || !mem_ctl.semaphore_select_n) && mem_data_oe)
    else $error("write strobe without select or data");
  a_pulse_width: assert property (
    $fell(mem_ctl.read_write_n) |-> s_strobe) else $error("short strobe");
  a_oe_off_drive: assert property (
    mem_data_oe |-> mem_ctl.output_enable_n) else $error("data clash");
  a_sem_no_cs: assert property (
    !mem_ctl.semaphore_select_n |-> mem_ctl.chip_select_n)
    else $error("chip select low in semaphore access");
  a_sem_bit0: assert property (
    s_take |-> ##[1:6] (!mem_ctl.semaphore_select_n
      && !mem_ctl.read_write_n && mem_data_out == 8'hFE))
    else $error("semaphore request not written low");
  a_busy_holds: assert property (
    !mem_busy_n [*5] ##0 !mem_ctl.read_write_n |=> !mem_ctl.read_write_n)
    else $error("write ended while busy low");
  a_irq_level: assert property (
    (!mem_int_n) [*5] |-> irq_pending) else $error("flag not reported");
  a_irq_clear: assert property (
    mem_int_n [*5] |-> !irq_pending) else $error("flag not cleared");
  a_rsp_single: assert property (
    rsp_valid |-> req_ready ##1 !rsp_valid) else $error("bad response");
endmodule
bind dpram_port_ctrl dpram_port_checker u_chk (.clk(clk), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .rsp_valid(rsp_valid), .irq_pending(irq_pending), .mem_addr(mem_addr),
  .mem_ctl(mem_ctl), .mem_data_out(mem_data_out),
  .mem_data_oe(mem_data_oe), .mem_busy_n(mem_busy_n),
  .mem_int_n(mem_int_n));

// File: testbench/dpram_model.sv
// behavioural two-port memory, left port pins, far port as hooks
module dpram_model (
  input wire logic clk,
  input wire logic [12:0] addr,
  input wire dpram_ctrl_pkg::port_ctl_t ctl,
  input wire logic [7:0] wdata,
  input wire logic wdata_oe,
  input wire logic far_post,
  input wire logic [7:0] far_sem_hold,
  output logic [7:0] rdata,
  output logic int_n,
  output logic far_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:8191];
  logic [7:0] sem_own = 8'h00;
  logic [7:0] noise = 8'h3C;
  logic own_flag = 1'b0;
  logic wr_sem, wr_on, rd_on, clr_hit;
  logic [12:0] wr_addr;
  initial far_flag = 1'b0;
  assign wr_on = (!ctl.chip_select_n || !ctl.semaphore_select_n)
    && !ctl.read_write_n;
  assign rd_on = ctl.read_write_n && !ctl.output_enable_n
    && (!ctl.chip_select_n || !ctl.semaphore_select_n);
  assign clr_hit = rd_on && !ctl.chip_select_n && addr == 13'h1FFE;
  assign int_n = !own_flag;
  // released bus toggles so a stale value is never mistaken for data
  always @(posedge clk) noise <= ~noise;
  always @(posedge wr_on) begin
    wr_sem = !ctl.semaphore_select_n;
    wr_addr = addr;
  end
  // write lands when either select or read/write rises
  always @(negedge wr_on) begin
    if (wr_sem) begin
      sem_own[wr_addr[2:0]] = wdata_oe && !wdata[0]
        && !far_sem_hold[wr_addr[2:0]];
    end else begin
      mem[wr_addr] = wdata_oe ? wdata : 8'hXX;
      if (wr_addr == 13'h1FFF) far_flag = 1'b1;
    end
  end
  always @(posedge far_post) own_flag = 1'b1;
  always @(posedge clr_hit) own_flag = 1'b0;
  always @* begin
    if (rd_on && !ctl.chip_select_n) rdata = mem[addr];
    else if (rd_on) rdata = {7'h7F, !sem_own[addr[2:0]]};
    else rdata = noise;
  end
endmodule

// File: testbench/tb_dpram_port_ctrl.sv
// testbench: memory port controller against the memory model
module tb_dpram_port_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic mem_busy_n = 1'b1;
  logic far_post = 1'b0;
  logic [7:0] far_sem_hold = 8'h00;
  dpram_ctrl_pkg::req_t req = '0;
  dpram_ctrl_pkg::port_ctl_t mem_ctl;
  logic req_ready, rsp_valid, rsp_granted, irq_pending, busy_seen;
  logic mem_data_oe, int_n, far_flag;
  logic [7:0] rsp_data, mem_data_out, mem_rdata;
  logic [12:0] mem_addr;
  int err_count = 0;
  int total_checks = 0;
  int lat;
  always #10 clk = ~clk;
  dpram_port_ctrl #(.IS_LEFT(1'b1)) DUT (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_granted(rsp_granted),
    .irq_pending(irq_pending), .busy_seen(busy_seen), .mem_addr(mem_addr),
    .mem_ctl(mem_ctl), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_data_in(mem_rdata),
    .mem_busy_n(mem_busy_n), .mem_int_n(int_n));
  dpram_model partner (.clk(clk), .addr(mem_addr), .ctl(mem_ctl),
    .wdata(mem_data_out), .wdata_oe(mem_data_oe), .far_post(far_post),
    .far_sem_hold(far_sem_hold), .rdata(mem_rdata), .int_n(int_n),
    .far_flag(far_flag));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(string what, logic exp, logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask
  // one request, held for one clock whether taken or not, then a bounded wait for the answer
  task automatic run(dpram_ctrl_pkg::cmd_t cmd, logic [12:0] a,
                     logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{cmd: cmd, addr: a, wdata: d};
    @(negedge clk);
    req_valid = 1'b0;
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < 60) begin
      @(negedge clk);
      lat++;
    end
    if (lat == 60) begin
      chk_bit("response", 1'b1, 1'b0);
      wrap_up();
    end
  endtask
  task automatic wait_irq(logic v);
    for (int i = 0; i < 12 && irq_pending !== v; i++) @(negedge clk);
    chk_bit("interrupt pending", v, irq_pending);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_data();
    run(dpram_ctrl_pkg::CMD_WRITE, 13'h0123, 8'hA5);
    run(dpram_ctrl_pkg::CMD_WRITE, 13'h0124, 8'h5A);
    run(dpram_ctrl_pkg::CMD_READ, 13'h0123, 8'h00);
    chk("read 0123", 8'hA5, rsp_data);
    run(dpram_ctrl_pkg::CMD_READ, 13'h0124, 8'h00);
    chk("read 0124", 8'h5A, rsp_data);
    $display("test data done");
  endtask
  task automatic t_sem();
    run(dpram_ctrl_pkg::CMD_SEM_TAKE, 13'h0003, 8'h00);
    chk_bit("semaphore granted", 1'b1, rsp_granted);
    chk("semaphore readback", 8'hFE, rsp_data);
    run(dpram_ctrl_pkg::CMD_SEM_FREE, 13'h0003, 8'h00);
    chk("semaphore freed", 8'hFF, rsp_data);
    far_sem_hold = 8'h08;
    run(dpram_ctrl_pkg::CMD_SEM_TAKE, 13'h0003, 8'h00);
    chk_bit("semaphore held far", 1'b0, rsp_granted);
    far_sem_hold = 8'h00;
    $display("test semaphore done");
  endtask
  task automatic t_busy();
    fork
      begin
        mem_busy_n = 1'b0;
        repeat (16) @(negedge clk);
        mem_busy_n = 1'b1;
      end
      begin
        // let busy pass the input flops before the strobe starts
        repeat (4) @(negedge clk);
        run(dpram_ctrl_pkg::CMD_WRITE, 13'h0200, 8'h3C);
      end
    join
    chk_bit("busy seen", 1'b1, busy_seen);
    chk_bit("write held off", 1'b1, lat > 10);
    run(dpram_ctrl_pkg::CMD_READ, 13'h0200, 8'h00);
    chk("read after busy", 8'h3C, rsp_data);
    chk_bit("busy cleared", 1'b0, busy_seen);
    $display("test busy done");
  endtask
  task automatic t_mail();
    run(dpram_ctrl_pkg::CMD_WRITE, dpram_ctrl_pkg::MAILBOX_RIGHT, 8'h11);
    chk_bit("far flag", 1'b1, far_flag);
    far_post = 1'b1;
    @(negedge clk);
    far_post = 1'b0;
    wait_irq(1'b1);
    run(dpram_ctrl_pkg::CMD_READ, dpram_ctrl_pkg::MAILBOX_LEFT, 8'h00);
    wait_irq(1'b0);
    $display("test mailbox done");
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_data();
    t_sem();
    t_busy();
    t_mail();
    wrap_up();
  end
endmodule
